/* oht_core_model.sv */
// Behavioural drive control core that runs, trips and meters energy
module oht_core_model
	import oht_pkg::*;
#(
	parameter int LIVE_W = 32
)
(
	input  wire logic                clock,
	output logic                     drive_running,
	output logic                     trip_event,
	output logic      [CAUSE_W-1:0]  trip_cause,
	output logic      [INTERN_W-1:0] trip_internal,
	output logic                     energy_wh_inc,
	output logic      [LIVE_W-1:0]   live_values
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [LIVE_W-1:0] snap; // Live values presented with the last trip
	initial
	begin
		{drive_running, trip_event, energy_wh_inc} = 3'h0;
		{trip_cause, trip_internal} = 16'h0;
		live_values = '0;
	end
	// Status moves every cycle so a late or early capture shows
	always @(posedge clock)
		live_values <= live_values + LIVE_W'(32'h9e3779b9);
	// Run state change
	task run(input logic r);
		@(posedge clock);
		drive_running <= r;
	endtask : run
	// One trip, cause garbled again once the pulse ends
	task trip(input logic [CAUSE_W-1:0] c, input logic [INTERN_W-1:0] n);
		@(posedge clock);
		{trip_event, trip_cause, trip_internal} <= {1'b1, c, n};
		@(posedge clock);
		snap = live_values;
		{trip_event, trip_cause, trip_internal} <= {1'b0, ~c, ~n};
	endtask : trip
	// One watt-hour consumed
	task wh();
		@(posedge clock);
		energy_wh_inc <= 1'b1;
		@(posedge clock);
		energy_wh_inc <= 1'b0;
	endtask : wh
endmodule : oht_core_model

/* oht_logger.sv */
// Operating hours, energy and trip history logger of the drive
// Functional notes
// - Run time counts only while drive runs
// - Writing 1 clears run time, restarts
// - Run time clear setting reverts to 0
// - Mains timer counts while powered, never clears
// - Energy counts Wh, wraps after 1 GWh
// - Energy clear zeroes, setting self-reverts
// - Accumulators saved at power down, restored
// - History keeps newest nine trip records
// - Tenth trip discards the oldest record
// - Trip copies live values and accumulators
// - Calendar present: stamp with date and time
// - No calendar: stamp with run time
// - Cause in bits 0-5, internal 6-15
// - Writing 1 erases all nine records
// - Log clear self-reverts, OK held 2 s
module oht_logger
	import oht_pkg::*;
#(
	parameter int LIVE_W      = 256,               // Live snapshot width
	parameter int TICK_CYCLES = CLK_HZ * TICK_S,   // Cycles per second
	parameter int OK_CYCLES   = CLK_HZ * OK_HOLD_S // Completion hold
)
(
	input  wire logic                clock,
	input  wire logic                rst,
	input  wire logic                drive_running,
	input  wire logic                trip_event,
	input  wire logic [CAUSE_W-1:0]  trip_cause,
	input  wire logic [INTERN_W-1:0] trip_internal,
	input  wire logic                energy_wh_inc,
	input  wire logic [LIVE_W-1:0]   live_values,
	input  wire logic                rtc_present,
	input  wire logic [YEAR_W-1:0]   rtc_year,
	input  wire logic [MONTH_W-1:0]  rtc_month,
	input  wire logic [DAY_W-1:0]    rtc_day,
	input  wire logic [HOUR_W-1:0]   rtc_hours,
	input  wire logic [MS_W-1:0]     rtc_minutes,
	input  wire logic [MS_W-1:0]     rtc_seconds,
	input  wire logic                run_time_clear_wr,
	input  wire logic                run_time_clear_wdata,
	input  wire logic                energy_clear_wr,
	input  wire logic                energy_clear_wdata,
	input  wire logic                trip_log_clear_wr,
	input  wire logic                trip_log_clear_wdata,
	input  wire logic                power_down,
	input  wire logic                power_up,
	input  wire logic [TIME_W-1:0]   nv_run_time,
	input  wire logic [TIME_W-1:0]   nv_mains_time,
	input  wire logic [ENERGY_W-1:0] nv_energy,
	input  wire logic [IDX_W-1:0]    log_rd_index,
	output logic      [TIME_W-1:0]   run_time_q,
	output logic      [TIME_W-1:0]   mains_time_q,
	output logic      [ENERGY_W-1:0] energy_wh_q,
	output logic                     run_time_clear_q,
	output logic                     energy_clear_q,
	output logic                     trip_log_clear_q,
	output logic                     trip_log_ok_q,
	output logic                     nv_save_q,
	output logic      [TIME_W-1:0]   nv_run_time_q,
	output logic      [TIME_W-1:0]   nv_mains_time_q,
	output logic      [ENERGY_W-1:0] nv_energy_q,
	output logic      [IDX_W-1:0]    log_count_q,
	output logic                     log_valid_q,
	output logic      [WORD_W-1:0]   log_cause_word_q,
	output logic      [STAMP_W-1:0]  log_stamp_q,
	output logic                     log_stamp_rtc_q,
	output logic      [TIME_W-1:0]   log_run_q,
	output logic      [TIME_W-1:0]   log_mains_q,
	output logic      [ENERGY_W-1:0] log_energy_q,
	output logic      [LIVE_W-1:0]   log_live_q
);

	localparam int REC_W  = REC_LIVE_LSB + LIVE_W;     // Trip record width
	localparam int TICK_W = $clog2(TICK_CYCLES);
	localparam int OK_W   = $clog2(OK_CYCLES + 1);
	localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);
	localparam logic [OK_W-1:0]   OK_LOAD   = OK_W'(OK_CYCLES);

	// Timebase state
	logic [TICK_W-1:0] tick_cnt_q;   // Cycles into the current second
	logic [TICK_W-1:0] tick_cnt_d;
	logic              tick_q;       // One-cycle second pulse
	logic              tick_d;

	// Power and persistence state
	logic                powered_q;  // Supply present
	logic                powered_d;
	logic                nv_save_d;
	logic [TIME_W-1:0]   nv_run_d;
	logic [TIME_W-1:0]   nv_mains_d;
	logic [ENERGY_W-1:0] nv_energy_d;

	// Clear settings and energy
	logic                run_clr_d;
	logic                en_clr_d;
	logic [ENERGY_W-1:0] energy_d;

	// Trip log clear sequencer
	oht_tlc_t            tlc_q;
	oht_tlc_t            tlc_d;
	logic                tl_clr_d;
	logic                ok_d;
	logic [OK_W-1:0]     ok_cnt_q;   // Cycles of completion left
	logic [OK_W-1:0]     ok_cnt_d;
	logic                log_erase;  // Erase strobe to the store

	// Trip record assembly
	logic [WORD_W-1:0]  cause_word;
	logic [STAMP_W-1:0] stamp;
	logic [REC_W-1:0]   trip_rec;
	logic [REC_W-1:0]   rd_rec;

	// One-second tick derived from the system clock
	always_comb
	begin
		tick_d     = 1'b0;
		tick_cnt_d = tick_cnt_q + 1'b1;
		if (tick_cnt_q == TICK_LAST)
		begin
			tick_cnt_d = '0;
			tick_d     = 1'b1;
		end
	end

	// Timebase registers
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			tick_cnt_q <= '0;
			tick_q     <= 1'b0;
		end
		else
		begin
			tick_cnt_q <= tick_cnt_d;
			tick_q     <= tick_d;
		end
	end

	// Run time accumulator, counts only in run
	oht_time_acc u_run_time
	(
		.clock    (clock),
		.rst      (rst),
		.tick     (tick_q),
		.count_en (powered_q && drive_running),
		.clear    (run_time_clear_q),
		.load     (power_up),
		.load_val (nv_run_time),
		.value_q  (run_time_q)
	);

	// Mains time accumulator; its clear is tied off so it cannot reset
	oht_time_acc u_mains_time
	(
		.clock    (clock),
		.rst      (rst),
		.tick     (tick_q),
		.count_en (powered_q),
		.clear    (1'b0),
		.load     (power_up),
		.load_val (nv_mains_time),
		.value_q  (mains_time_q)
	);

	// Supply flag and snapshot for non-volatile storage
	always_comb
	begin
		powered_d   = powered_q;
		nv_save_d   = 1'b0;
		nv_run_d    = nv_run_time_q;
		nv_mains_d  = nv_mains_time_q;
		nv_energy_d = nv_energy_q;
		if (power_down)
		begin
			// Freeze counters and hand values to storage
			powered_d   = 1'b0;
			nv_save_d   = 1'b1;
			nv_run_d    = run_time_q;
			nv_mains_d  = mains_time_q;
			nv_energy_d = energy_wh_q;
		end
		else if (power_up)
			powered_d = 1'b1;
	end

	// Persistence registers
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			powered_q       <= 1'b1;
			nv_save_q       <= 1'b0;
			nv_run_time_q   <= TIME_ZERO;
			nv_mains_time_q <= TIME_ZERO;
			nv_energy_q     <= ENERGY_ZERO;
		end
		else
		begin
			powered_q       <= powered_d;
			nv_save_q       <= nv_save_d;
			nv_run_time_q   <= nv_run_d;
			nv_mains_time_q <= nv_mains_d;
			nv_energy_q     <= nv_energy_d;
		end
	end

	// Run time and energy clear settings and energy count
	always_comb
	begin
		// A setting holds one cycle, then reverts once the clear is done
		run_clr_d = run_time_clear_wr &&
			(run_time_clear_wdata == SET_YES);
		en_clr_d  = energy_clear_wr &&
			(energy_clear_wdata == SET_YES);
		energy_d  = energy_wh_q;
		if (energy_clear_q)
			energy_d = ENERGY_ZERO;
		else if (power_up)
			energy_d = nv_energy;
		else if (energy_wh_inc && powered_q)
		begin
			// Passing 1 GWh restarts at zero
			if (energy_wh_q >= ENERGY_MAX)
				energy_d = ENERGY_ZERO;
			else
				energy_d = energy_wh_q + 30'h1;
		end
	end

	// Clear setting and energy registers
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			run_time_clear_q <= 1'b0;
			energy_clear_q   <= 1'b0;
			energy_wh_q      <= ENERGY_ZERO;
		end
		else
		begin
			run_time_clear_q <= run_clr_d;
			energy_clear_q   <= en_clr_d;
			energy_wh_q      <= energy_d;
		end
	end

	// Trip log clear: erase, revert the setting, then show completion
	always_comb
	begin
		tlc_d     = tlc_q;
		tl_clr_d  = trip_log_clear_q;
		ok_d      = trip_log_ok_q;
		ok_cnt_d  = ok_cnt_q;
		log_erase = 1'b0;
		unique case (tlc_q)
			OHT_TLC_IDLE:
			begin
				// Wait for a write of 1
				if (trip_log_clear_wr && trip_log_clear_wdata == SET_YES)
				begin
					tl_clr_d = 1'b1;
					tlc_d    = OHT_TLC_ERASE;
				end
			end
			OHT_TLC_ERASE:
			begin
				// Erase all records and revert the setting
				log_erase = 1'b1;
				tl_clr_d  = 1'b0;
				ok_d      = 1'b1;
				ok_cnt_d  = OK_LOAD;
				tlc_d     = OHT_TLC_SHOW;
			end
			OHT_TLC_SHOW:
			begin
				// Hold completion for two seconds, a new write restarts
				ok_cnt_d = ok_cnt_q - 1'b1;
				if (trip_log_clear_wr && trip_log_clear_wdata == SET_YES)
				begin
					tl_clr_d = 1'b1;
					ok_d     = 1'b0;
					tlc_d    = OHT_TLC_ERASE;
				end
				else if (ok_cnt_q == OK_W'(1))
				begin
					ok_d  = 1'b0;
					tlc_d = OHT_TLC_IDLE;
				end
			end
			default:
			begin
				// Unused code returns to idle
				tl_clr_d = 1'b0;
				ok_d     = 1'b0;
				tlc_d    = OHT_TLC_IDLE;
			end
		endcase
	end

	// Trip log clear registers
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			tlc_q            <= OHT_TLC_IDLE;
			trip_log_clear_q <= 1'b0;
			trip_log_ok_q    <= 1'b0;
			ok_cnt_q         <= '0;
		end
		else
		begin
			tlc_q            <= tlc_d;
			trip_log_clear_q <= tl_clr_d;
			trip_log_ok_q    <= ok_d;
			ok_cnt_q         <= ok_cnt_d;
		end
	end

	// Record built from live values at the trip
	always_comb
	begin
		cause_word = '0;
		cause_word[CAUSE_LSB +: CAUSE_W]   = trip_cause;
		cause_word[INTERN_LSB +: INTERN_W] = trip_internal;
		if (rtc_present)
			stamp = {rtc_year, rtc_month, rtc_day, rtc_hours,
				rtc_minutes, rtc_seconds};
		else
			stamp = STAMP_W'(run_time_q);
		trip_rec = '0;
		trip_rec[REC_CAUSE_LSB +: WORD_W]    = cause_word;
		trip_rec[REC_STAMP_LSB +: STAMP_W]   = stamp;
		trip_rec[REC_RTC_BIT]                = rtc_present;
		trip_rec[REC_RUN_LSB +: TIME_W]      = run_time_q;
		trip_rec[REC_MAINS_LSB +: TIME_W]    = mains_time_q;
		trip_rec[REC_ENERGY_LSB +: ENERGY_W] = energy_wh_q;
		trip_rec[REC_LIVE_LSB +: LIVE_W]     = live_values;
	end

	// Trip history store
	oht_trip_mem #(
		.DEPTH (LOG_DEPTH),
		.REC_W (REC_W)
	) u_trip_mem
	(
		.clock      (clock),
		.rst        (rst),
		.push       (trip_event),
		.push_rec   (trip_rec),
		.clear      (log_erase),
		.rd_idx     (log_rd_index),
		.rd_valid_q (log_valid_q),
		.rd_rec_q   (rd_rec),
		.count_q    (log_count_q)
	);

	// Read fields of the selected record
	assign log_cause_word_q = rd_rec[REC_CAUSE_LSB +: WORD_W];
	assign log_stamp_q      = rd_rec[REC_STAMP_LSB +: STAMP_W];
	assign log_stamp_rtc_q  = rd_rec[REC_RTC_BIT];
	assign log_run_q        = rd_rec[REC_RUN_LSB +: TIME_W];
	assign log_mains_q      = rd_rec[REC_MAINS_LSB +: TIME_W];
	assign log_energy_q     = rd_rec[REC_ENERGY_LSB +: ENERGY_W];
	assign log_live_q       = rd_rec[REC_LIVE_LSB +: LIVE_W];

endmodule : oht_logger

/* oht_logger_bench.sv */
// Self-checking bench of the operating hours and trip logger
module oht_logger_bench;
	import oht_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int TK = 10; // Cycles per second in this run
	localparam int OK = 20; // Completion hold in this run
	localparam int LW = 32; // Live snapshot width
	localparam logic [TIME_W-1:0] TMAX = {HOURS_MAX, MS_MAX, MS_MAX};
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic drive_running, trip_event, energy_wh_inc, rtc_present;
	logic [CAUSE_W-1:0] trip_cause;
	logic [INTERN_W-1:0] trip_internal;
	logic [LW-1:0] live_values, log_live_q, live_exp [1:10];
	logic [YEAR_W-1:0] rtc_year;
	logic [MONTH_W-1:0] rtc_month;
	logic [DAY_W-1:0] rtc_day;
	logic [HOUR_W-1:0] rtc_hours;
	logic [MS_W-1:0] rtc_minutes, rtc_seconds;
	logic [2:0] wr, wd; // Run, energy, log clear writes
	logic [1:0] pwr; // Supply down, up
	logic [TIME_W-1:0] nv_run_time, nv_mains_time, run_time_q, m;
	logic [TIME_W-1:0] mains_time_q, nv_run_time_q, log_run_q;
	logic [TIME_W-1:0] nv_mains_time_q;
	logic [ENERGY_W-1:0] nv_energy, energy_wh_q, nv_energy_q, log_energy_q;
	logic [IDX_W-1:0] log_rd_index, log_count_q;
	logic run_time_clear_q, trip_log_ok_q, nv_save_q;
	logic log_valid_q, log_stamp_rtc_q;
	logic [WORD_W-1:0] log_cause_word_q;
	logic [STAMP_W-1:0] log_stamp_q;
	int bad_count = 0;
	int samples_checked = 0;
	int n;

	always #4 clock = ~clock;

	oht_core_model #(.LIVE_W(LW)) core (.clock, .drive_running,
		.trip_event, .trip_cause, .trip_internal, .energy_wh_inc,
		.live_values);
	oht_logger #(.LIVE_W(LW), .TICK_CYCLES(TK), .OK_CYCLES(OK)) uut (
		.clock, .rst, .drive_running, .trip_event, .trip_cause,
		.trip_internal, .energy_wh_inc, .live_values, .rtc_present,
		.rtc_year, .rtc_month, .rtc_day, .rtc_hours, .rtc_minutes,
		.rtc_seconds, .run_time_clear_wr(wr[0]),
		.run_time_clear_wdata(wd[0]), .energy_clear_wr(wr[1]),
		.energy_clear_wdata(wd[1]), .trip_log_clear_wr(wr[2]),
		.trip_log_clear_wdata(wd[2]), .power_down(pwr[0]),
		.power_up(pwr[1]), .nv_run_time, .nv_mains_time, .nv_energy,
		.log_rd_index, .run_time_q, .mains_time_q, .energy_wh_q,
		.run_time_clear_q, .energy_clear_q(), .trip_log_clear_q(),
		.trip_log_ok_q, .nv_save_q, .nv_run_time_q, .nv_mains_time_q,
		.nv_energy_q, .log_count_q, .log_valid_q, .log_cause_word_q,
		.log_stamp_q, .log_stamp_rtc_q, .log_run_q, .log_mains_q(),
		.log_energy_q, .log_live_q);

	// Compare and count
	task chk(input logic [63:0] seen, input logic [63:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	// Verdict and end of run
	task close_out();
		$display("checks=%0d bad=%0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : close_out
	// Let n edges pass, then step off the edge
	task cyc(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : cyc
	// Write one clear setting
	task setting(input int k, input logic d);
		@(posedge clock);
		{wr[k], wd[k]} <= {1'b1, d};
		@(posedge clock);
		wr[k] <= 1'b0;
		#1;
	endtask : setting
	// Supply event pulse
	task pulse(input int k);
		@(posedge clock);
		pwr[k] <= 1'b1;
		@(posedge clock);
		pwr[k] <= 1'b0;
		#1;
	endtask : pulse
	// Wait for a mains step, which marks a timebase tick
	task tick();
		m = mains_time_q;
		for (int i = 0; i < 3 * TK && mains_time_q === m; i++)
			@(negedge clock);
		chk(mains_time_q === m, 1'b0);
	endtask : tick

	// Watchdog sized well above the few hundred cycles needed
	initial
	begin
		#100us;
		bad_count++;
		close_out();
	end

	initial
	begin
		{wr, wd, pwr, rtc_present, log_rd_index} = '0;
		{rtc_year, rtc_month, rtc_day, rtc_hours} = '0;
		{rtc_minutes, rtc_seconds} = '0;
		nv_run_time = {18'd5, 6'd59, 6'd58};
		nv_mains_time = 30'h1000;
		nv_energy = ENERGY_MAX;
		repeat (16) @(posedge clock);
		rst <= 1'b0;
		cyc(1);
		chk(run_time_q, 0);
		chk(log_count_q, 0);
		// Run time counts only while running
		tick();
		core.run(1'b1);
		repeat (3) tick();
		core.run(1'b0);
		cyc(1);
		chk(run_time_q, 3);
		tick();
		chk(run_time_q, 3);
		// Restore, energy wrap and seconds and minutes carry
		pulse(1);
		chk(run_time_q, nv_run_time);
		chk(energy_wh_q, ENERGY_MAX);
		core.wh();
		cyc(1);
		chk(energy_wh_q, 0);
		tick();
		core.run(1'b1);
		repeat (2) tick();
		core.run(1'b0);
		cyc(1);
		chk(run_time_q, {18'd6, 12'd0});
		core.wh();
		// Ten trips, calendar present on odd ones
		for (int i = 1; i <= 10; i++)
		begin
			@(posedge clock);
			rtc_present <= i[0];
			{rtc_year, rtc_month, rtc_day} <= {7'(i + 20), 4'(i), 5'(i)};
			{rtc_hours, rtc_minutes, rtc_seconds} <= {5'(i), 6'(i), 6'(i)};
			core.trip(6'(i), 10'(3 * i));
			live_exp[i] = core.snap;
		end
		cyc(1);
		chk(log_count_q, 9);
		// Newest first; the oldest has gone
		for (int k = 0; k < 10; k++)
		begin
			n = 10 - k;
			@(posedge clock);
			log_rd_index <= 4'(k);
			cyc(2);
			chk(log_valid_q, k < 9);
			if (k < 9)
			begin
				chk(log_cause_word_q, {10'(3 * n), 6'(n)});
				chk(log_live_q, live_exp[n]);
				chk(log_energy_q, 1);
				chk(log_run_q, {18'd6, 12'd0});
				chk(log_stamp_rtc_q, n[0]);
				chk(log_stamp_q, n[0] ? {7'(n + 20), 4'(n), 5'(n), 5'(n),
					6'(n), 6'(n)} : {3'h0, 18'd6, 12'd0});
			end
		end
		// Clear settings: zero data is ignored, one clears
		setting(0, 1'b0);
		cyc(2);
		chk(run_time_q, {18'd6, 12'd0});
		setting(0, 1'b1);
		cyc(2);
		chk(run_time_q, 0);
		chk(run_time_clear_q, 0);
		chk(mains_time_q != 0, 1'b1);
		setting(1, 1'b1);
		cyc(2);
		chk(energy_wh_q, 0);
		// Log clear and its completion hold
		setting(2, 1'b1);
		n = 0;
		repeat (OK + 5) @(negedge clock) n += int'(trip_log_ok_q === 1'b1);
		chk(n, OK);
		chk(log_count_q, 0);
		// Supply loss saves and freezes
		pulse(0);
		chk(nv_save_q, 1'b1);
		chk(nv_run_time_q, 0);
		chk(nv_energy_q, 0);
		chk(nv_mains_time_q, mains_time_q);
		m = mains_time_q;
		cyc(3 * TK);
		chk(mains_time_q, m);
		// Both timers stop at their ceiling
		{nv_run_time, nv_mains_time} = {TMAX, TMAX};
		pulse(1);
		core.run(1'b1);
		cyc(3 * TK);
		chk(run_time_q, TMAX);
		chk(mains_time_q, TMAX);
		close_out();
	end
endmodule : oht_logger_bench

/* oht_logger_sva.sv */
// Concurrent checks on the ports of the operating hours and trip logger
module oht_logger_sva
	import oht_pkg::*;
(
	input wire logic                clock,
	input wire logic                rst,
	input wire logic                drive_running,
	input wire logic                trip_event,
	input wire logic                run_time_clear_wr,
	input wire logic                run_time_clear_wdata,
	input wire logic                energy_clear_wr,
	input wire logic                trip_log_clear_wr,
	input wire logic                power_down,
	input wire logic                power_up,
	input wire logic [TIME_W-1:0]   run_time_q,
	input wire logic [TIME_W-1:0]   mains_time_q,
	input wire logic [ENERGY_W-1:0] energy_wh_q,
	input wire logic                run_time_clear_q,
	input wire logic                energy_clear_q,
	input wire logic                trip_log_clear_q,
	input wire logic                trip_log_ok_q,
	input wire logic                nv_save_q,
	input wire logic [IDX_W-1:0]    log_count_q
);
	timeunit 1ns;
	timeprecision 1ps;
	// All checks share the one system clock and its reset
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	// A write of one raises the setting on the next edge
	property p_rclr_go;
		run_time_clear_wr && run_time_clear_wdata |=> run_time_clear_q;
	endproperty
	a_rclr_go: assert property (p_rclr_go)
		else $error("run clear write not taken");
	// Setting falls back alone while the run time reads zero
	property p_rclr_done;
		run_time_clear_q && !run_time_clear_wr |=>
			!run_time_clear_q && run_time_q == TIME_ZERO;
	endproperty
	a_rclr_done: assert property (p_rclr_done)
		else $error("run clear did not finish");
	// Energy clear zeroes the count and drops its setting
	property p_eclr;
		energy_clear_q && !energy_clear_wr |=>
			!energy_clear_q && energy_wh_q == ENERGY_ZERO;
	endproperty
	a_eclr: assert property (p_eclr)
		else $error("energy clear did not finish");
	// Log clear setting lasts one cycle, then the done flag shows
	property p_lclr;
		trip_log_clear_q && !trip_log_clear_wr |=>
			trip_log_ok_q && !trip_log_clear_q;
	endproperty
	a_lclr: assert property (p_lclr)
		else $error("log clear completion missing");
	// Erase with no trip alongside empties every record
	property p_lerase;
		trip_log_clear_q && !trip_event |=> log_count_q == 4'h0;
	endproperty
	a_lerase: assert property (p_lerase)
		else $error("log not emptied");
	// Never more than nine records held
	property p_depth;
		log_count_q <= 4'h9;
	endproperty
	a_depth: assert property (p_depth)
		else $error("log holds too many records");
	// Mains timer never goes back except by a restore
	property p_mains_up;
		!power_up |=> mains_time_q >= $past(mains_time_q);
	endproperty
	a_mains_up: assert property (p_mains_up)
		else $error("mains timer went back");
	// Run time frozen while the drive is stopped
	property p_run_hold;
		!drive_running && !power_up && !run_time_clear_q |=>
			$stable(run_time_q);
	endproperty
	a_run_hold: assert property (p_run_hold)
		else $error("run time moved while stopped");
	// Supply loss hands the values to storage on the next edge
	property p_save;
		power_down |=> nv_save_q;
	endproperty
	a_save: assert property (p_save)
		else $error("save pulse missing");

	c_trip: cover property (log_count_q == 4'h9);
	c_ok: cover property (trip_log_ok_q);
	c_up: cover property (power_up);
endmodule : oht_logger_sva

bind oht_logger oht_logger_sva u_sva (.clock, .rst, .drive_running,
	.trip_event, .run_time_clear_wr, .run_time_clear_wdata,
	.energy_clear_wr, .trip_log_clear_wr, .power_down, .power_up,
	.run_time_q, .mains_time_q, .energy_wh_q, .run_time_clear_q,
	.energy_clear_q, .trip_log_clear_q, .trip_log_ok_q, .nv_save_q,
	.log_count_q);

/* oht_pkg.sv */
// Shared constants and types for the operating hours and trip logger
package oht_pkg;

	// Clock rate and documented times
	localparam int CLK_HZ    = 125_000_000;  // System clock in Hz
	localparam int TICK_S    = 1;            // Timebase period in seconds
	localparam int OK_HOLD_S = 2;            // Log clear completion hold, s

	// Time accumulator layout {hours, minutes, seconds}
	localparam int HOURS_W = 18;
	localparam int MS_W    = 6;
	localparam int TIME_W  = HOURS_W + 2 * MS_W;
	localparam int SEC_LSB = 0;
	localparam int MIN_LSB = MS_W;
	localparam int HR_LSB  = 2 * MS_W;
	localparam logic [HOURS_W-1:0] HOURS_MAX = 18'h3ffff; // 262143 hours
	localparam logic [MS_W-1:0]    MS_MAX    = 6'h3b;     // 59
	localparam logic [TIME_W-1:0]  TIME_ZERO = 30'h0;

	// Energy accumulator in watt-hours, wraps after 1 GWh
	localparam int ENERGY_W = 30;
	localparam logic [ENERGY_W-1:0] ENERGY_MAX  = 30'h3b9aca00;
	localparam logic [ENERGY_W-1:0] ENERGY_ZERO = 30'h0;

	// Trip cause word layout
	localparam int WORD_W    = 16;
	localparam int CAUSE_W   = 6;   // Cause code, bits 0 to 5
	localparam int INTERN_W  = 10;  // Internal use, bits 6 to 15
	localparam int CAUSE_LSB = 0;
	localparam int INTERN_LSB = CAUSE_W;

	// Calendar stamp layout {year, month, day, hours, minutes, seconds}
	localparam int YEAR_W  = 7;
	localparam int MONTH_W = 4;
	localparam int DAY_W   = 5;
	localparam int HOUR_W  = 5;
	localparam int STAMP_W = YEAR_W + MONTH_W + DAY_W + HOUR_W + 2 * MS_W;

	// Trip record field positions
	localparam int LOG_DEPTH      = 9;
	localparam int IDX_W          = 4;
	localparam int REC_CAUSE_LSB  = 0;
	localparam int REC_STAMP_LSB  = REC_CAUSE_LSB + WORD_W;
	localparam int REC_RTC_BIT    = REC_STAMP_LSB + STAMP_W;
	localparam int REC_RUN_LSB    = REC_RTC_BIT + 1;
	localparam int REC_MAINS_LSB  = REC_RUN_LSB + TIME_W;
	localparam int REC_ENERGY_LSB = REC_MAINS_LSB + TIME_W;
	localparam int REC_LIVE_LSB   = REC_ENERGY_LSB + ENERGY_W;

	// Value that requests a clear when written to a clear setting
	localparam logic SET_YES = 1'b1;

	// Trip log clear sequencer
	typedef enum logic [1:0]
	{
		OHT_TLC_IDLE  = 2'b00,
		OHT_TLC_ERASE = 2'b01,
		OHT_TLC_SHOW  = 2'b10
	} oht_tlc_t;

endpackage : oht_pkg

/* oht_time_acc.sv */
// Hours, minutes and seconds accumulator advanced by a one-second tick
module oht_time_acc
	import oht_pkg::*;
(
	input  wire logic              clock,
	input  wire logic              rst,
	input  wire logic              tick,
	input  wire logic              count_en,
	input  wire logic              clear,
	input  wire logic              load,
	input  wire logic [TIME_W-1:0] load_val,
	output logic      [TIME_W-1:0] value_q
);

	logic [TIME_W-1:0]  value_d;  // Next accumulated time
	logic [HOURS_W-1:0] hr;       // Hours field of current value
	logic [MS_W-1:0]    mn;       // Minutes field
	logic [MS_W-1:0]    sc;       // Seconds field

	// Next time value: clear, restore, or one-second advance
	always_comb
	begin
		hr = value_q[HR_LSB +: HOURS_W];
		mn = value_q[MIN_LSB +: MS_W];
		sc = value_q[SEC_LSB +: MS_W];
		value_d = value_q;
		if (clear)
		begin
			// Fresh period from zero
			value_d = TIME_ZERO;
		end
		else if (load)
		begin
			// Restored from non-volatile storage
			value_d = load_val;
		end
		else if (tick && count_en)
		begin
			// Seconds roll into minutes, minutes into hours
			if (sc != MS_MAX)
				sc = sc + 6'h01;
			else if (mn != MS_MAX)
			begin
				sc = '0;
				mn = mn + 6'h01;
			end
			else if (hr != HOURS_MAX)
			begin
				sc = '0;
				mn = '0;
				hr = hr + 18'h00001;
			end
			// At full range the value holds
			value_d = {hr, mn, sc};
		end
	end

	// Time register
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			value_q <= TIME_ZERO;
		else
			value_q <= value_d;
	end

endmodule : oht_time_acc

/* oht_trip_mem.sv */
// Nine-deep first-in-first-out trip record store with newest-first read
module oht_trip_mem
	import oht_pkg::*;
#(
	parameter int DEPTH = LOG_DEPTH,
	parameter int REC_W = 64
)
(
	input  wire logic             clock,
	input  wire logic             rst,
	input  wire logic             push,
	input  wire logic [REC_W-1:0] push_rec,
	input  wire logic             clear,
	input  wire logic [IDX_W-1:0] rd_idx,
	output logic                  rd_valid_q,
	output logic      [REC_W-1:0] rd_rec_q,
	output logic      [IDX_W-1:0] count_q
);

	logic [REC_W-1:0] mem [DEPTH];  // Record storage
	logic [IDX_W-1:0] wr_ptr_q;     // Slot the next record goes to
	logic [IDX_W-1:0] wr_ptr_d;
	logic [IDX_W-1:0] count_d;
	logic             rd_valid_d;
	logic [IDX_W-1:0] rd_pos;       // Slot of the selected record

	// Slot after a given one, wrapping at the depth
	function automatic logic [IDX_W-1:0] slot_next(logic [IDX_W-1:0] s);
		return (s == IDX_W'(DEPTH - 1)) ? '0 : s + 4'h1;
	endfunction : slot_next

	// Slot holding the record that is idx places older than the newest
	function automatic logic [IDX_W-1:0] slot_back(logic [IDX_W-1:0] p,
		logic [IDX_W-1:0] idx);
		int s;
		s = int'(p) + DEPTH - 1 - int'(idx);
		if (s >= DEPTH)
			s = s - DEPTH;
		if (s < 0)
			s = s + DEPTH;
		return IDX_W'(s);
	endfunction : slot_back

	// Pointer and fill count; a push in the clearing cycle is kept
	always_comb
	begin
		wr_ptr_d = wr_ptr_q;
		count_d  = count_q;
		if (clear)
		begin
			// All records erased at once
			wr_ptr_d = '0;
			count_d  = '0;
		end
		if (push)
		begin
			wr_ptr_d = slot_next(clear ? '0 : wr_ptr_q);
			if (clear)
				count_d = 4'h1;
			else if (count_q != IDX_W'(DEPTH))
				count_d = count_q + 4'h1;
		end
		rd_pos     = slot_back(wr_ptr_q, rd_idx);
		rd_valid_d = (rd_idx < count_q);
	end

	// Pointer, count and read register
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			wr_ptr_q   <= '0;
			count_q    <= '0;
			rd_valid_q <= 1'b0;
			rd_rec_q   <= '0;
		end
		else
		begin
			wr_ptr_q   <= wr_ptr_d;
			count_q    <= count_d;
			rd_valid_q <= rd_valid_d;
			rd_rec_q   <= rd_valid_d ? mem[rd_pos] : '0;
		end
	end

	// Oldest slot is overwritten once all nine are full
	always_ff @(posedge clock)
	begin
		if (push)
			mem[clear ? '0 : wr_ptr_q] <= push_rec;
	end

endmodule : oht_trip_mem
